// File: rtl/pif_map.svh
`ifndef PIF_MAP_SVH
`define PIF_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PIF_OFF_EN_ONE  4'h0
`define PIF_OFF_EN_TWO  4'h4
`define PIF_OFF_REQ_ONE 4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PIF_BIT_GATE 7
`define PIF_BIT_CONV 6
`define PIF_BIT_RX   5
`define PIF_BIT_TX   4
`define PIF_BIT_SYNC 3
`define PIF_BIT_CC1  2
`define PIF_BIT_PM   1
`define PIF_BIT_OVF  0
`define PIF_BIT_CC2  0

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define PIF_RST_EN_ONE  8'h00
`define PIF_RST_EN_TWO  8'h00
`define PIF_RST_REQ_ONE 8'h00
`define PIF_EN_TWO_MASK 8'h01
`define PIF_REQ_WR_MASK 8'h4F

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define PIF_RESP_OKAY   2'h0
`define PIF_RESP_SLVERR 2'h2

`endif

// File: rtl/pif_pkg.sv
package pif_pkg;

  // ----------------------------------------
  // Register select
  // ----------------------------------------
  typedef enum logic [3:0] {
    PIF_SEL_EN_ONE  = 4'h1,
    PIF_SEL_EN_TWO  = 4'h2,
    PIF_SEL_REQ_ONE = 4'h4,
    PIF_SEL_NONE    = 4'h8
  } pif_sel_e;

  // ----------------------------------------
  // Whole block state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  en_one;
    logic [7:0]  en_two;
    logic [7:0]  req_one;
    logic        irq;
    logic        aw_got;
    pif_sel_e    aw_sel;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pif_state_s;

endpackage : pif_pkg

// File: rtl/pif_top.sv
`timescale 1ns/100ps
`include "pif_map.svh"

// Operation
// - Enable one bit 7: gate done enable
// - Enable one bit 6: conversion enable
// - Enable one bit 5: serial receive enable
// - Enable one bit 4: serial transmit enable
// - Enable one bit 3: sync port enable
// - Enable one bit 2: capcmp one enable
// - Enable one bit 1: period match enable
// - Enable one bit 0: timer one overflow enable
// - Enable two: only bit 0, rest zero
// - Nothing forwarded without peripheral gate set
// - Flags set regardless of any enable
// - Bit 7 reads one while gate inactive
// - Bit 6 set on conversion done
// - Bit 4 read-only, mirrors transmit empty
// - Bit 3 set on sync transfer done
// - Bit 2 capture/compare event, not PWM
// - Bit 1 set on period match
// - Bit 0 set on timer one overflow

module pif_top #(
  parameter int ADDR_W = 4
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        peripheral_int_gate,
  input  wire logic        gate_active,
  input  wire logic        conversion_done_evt,
  input  wire logic        serial_rx_full,
  input  wire logic        serial_tx_empty,
  input  wire logic        sync_port_done_evt,
  input  wire logic        capcmp_one_evt,
  input  wire logic        capcmp_one_pwm,
  input  wire logic        period_match_evt,
  input  wire logic        timer_one_ovf_evt,
  input  wire logic        capcmp_two_flag,
  output logic             peripheral_int_req,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  generate
    if (ADDR_W < 4) begin : g_bad_addr
      $error("pif_top needs ADDR_W of at least 4");
    end
  endgenerate

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Upper address bits must be zero, else the access is unmapped
  function automatic pif_pkg::pif_sel_e pif_decode(
    input logic [ADDR_W-1:0] addr
  );
    logic [ADDR_W-1:0] hi;
    pif_pkg::pif_sel_e sel;
    hi = addr >> 4;
    sel = pif_pkg::PIF_SEL_NONE;
    if (hi == '0) begin
      case (addr[3:0])
        `PIF_OFF_EN_ONE:  sel = pif_pkg::PIF_SEL_EN_ONE;
        `PIF_OFF_EN_TWO:  sel = pif_pkg::PIF_SEL_EN_TWO;
        `PIF_OFF_REQ_ONE: sel = pif_pkg::PIF_SEL_REQ_ONE;
        default:          sel = pif_pkg::PIF_SEL_NONE;
      endcase
    end
    return sel;
  endfunction : pif_decode

  // ----------------------------------------
  // State
  // ----------------------------------------
  pif_pkg::pif_state_s s_reg;
  pif_pkg::pif_state_s s_next;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [7:0] base;
    logic [7:0] evt;
    logic [7:0] pend;
    logic       wr_en;
    s_next = s_reg;
    base = s_reg.req_one;
    evt = 8'h00;
    pend = 8'h00;
    wr_en = 1'b0;

    // Write address and data are taken in either order
    if (s_reg.awready && s_axi_awvalid) begin
      s_next.aw_got = 1'b1;
      s_next.aw_sel = pif_decode(s_axi_awaddr);
    end
    if (s_reg.wready && s_axi_wvalid) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end

    // Commit a write once both halves are held
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = `PIF_RESP_OKAY;
      case (s_reg.aw_sel)
        pif_pkg::PIF_SEL_EN_ONE: begin
          if (s_reg.wstrb[0]) begin
            s_next.en_one = s_reg.wdata[7:0];
          end
        end
        pif_pkg::PIF_SEL_EN_TWO: begin
          if (s_reg.wstrb[0]) begin
            s_next.en_two = s_reg.wdata[7:0] & `PIF_EN_TWO_MASK;
          end
        end
        pif_pkg::PIF_SEL_REQ_ONE: begin
          wr_en = s_reg.wstrb[0];
        end
        default: begin
          s_next.bresp = `PIF_RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready = !s_next.w_got && !s_next.bvalid;

    // Reads answer from current state, one cycle after the address
    if (s_reg.arready && s_axi_arvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = `PIF_RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      case (pif_decode(s_axi_araddr))
        pif_pkg::PIF_SEL_EN_ONE: begin
          s_next.rdata[7:0] = s_reg.en_one;
        end
        pif_pkg::PIF_SEL_EN_TWO: begin
          s_next.rdata[7:0] = s_reg.en_two;
        end
        pif_pkg::PIF_SEL_REQ_ONE: begin
          s_next.rdata[7:0] = s_reg.req_one;
        end
        default: begin
          s_next.rresp = `PIF_RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    s_next.arready = !s_next.rvalid;

    // Software write replaces the writable flags; zero clears
    if (wr_en) begin
      base = (s_reg.req_one & ~`PIF_REQ_WR_MASK)
           | (s_reg.wdata[7:0] & `PIF_REQ_WR_MASK);
    end

    // Events ignore every enable and win over a clearing write
    evt[`PIF_BIT_CONV] = conversion_done_evt;
    evt[`PIF_BIT_SYNC] = sync_port_done_evt;
    evt[`PIF_BIT_CC1] = capcmp_one_evt && !capcmp_one_pwm;
    evt[`PIF_BIT_PM] = period_match_evt;
    evt[`PIF_BIT_OVF] = timer_one_ovf_evt;
    s_next.req_one = base | (evt & `PIF_REQ_WR_MASK);

    // Level-driven flags follow their sources, writes have no effect
    s_next.req_one[`PIF_BIT_GATE] = !gate_active;
    // Receive side drops its level when its data register is read
    s_next.req_one[`PIF_BIT_RX] = serial_rx_full;
    // Transmit side drops its level when its data register is written
    s_next.req_one[`PIF_BIT_TX] = serial_tx_empty;

    // Masked requests; bits map one to one onto enables
    pend = s_next.req_one & s_next.en_one;
    // Stale flags fire at once when enabled; software clears first
    s_next.irq = peripheral_int_gate
               && ((|pend)
                   || (capcmp_two_flag && s_next.en_two[`PIF_BIT_CC2]));
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Clock enable low freezes flags, enables and bus alike
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '{
        en_one:  `PIF_RST_EN_ONE,
        en_two:  `PIF_RST_EN_TWO,
        req_one: `PIF_RST_REQ_ONE,
        aw_sel:  pif_pkg::PIF_SEL_NONE,
        default: '0
      };
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign peripheral_int_req = s_reg.irq;
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;

endmodule : pif_top

// File: bench/pif_top_asserts.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checks
// ----------------------------------------
module pif_top_asserts #(
  parameter int ADDR_W = 4
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              peripheral_int_gate,
  input wire logic              peripheral_int_req,
  input wire logic              s_axi_awready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_irq_gate_off: assert property (
    !peripheral_int_gate |=> !peripheral_int_req) else $error("request with gate low");
  a_irq_rise_cause: assert property (
    $rose(peripheral_int_req) |-> $past(peripheral_int_gate)) else $error("request cause lost");
  a_rd_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_rd_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rd_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  a_rd_blocks_ar: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("address taken while busy");
  a_rd_unmapped: assert property (
    s_axi_arvalid && s_axi_arready && !(s_axi_araddr inside {4'h0, 4'h4, 4'h8})
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answer");
  a_wr_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_wr_blocks_aw: assert property (
    s_axi_bvalid |-> !s_axi_awready) else $error("write taken while busy");
  c_irq: cover property (peripheral_int_req);
  c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_rd_ok: cover property (s_axi_rvalid && s_axi_rresp == 2'h0);
endmodule : pif_top_asserts

bind pif_top pif_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .reset(reset),
  .peripheral_int_gate(peripheral_int_gate), .peripheral_int_req(peripheral_int_req),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// File: bench/pif_src.sv
`timescale 1ns/100ps
// ----------------------------------------
// Peripheral event sources
// ----------------------------------------
module pif_src (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [4:0] fire,
  output logic      [4:0] evt
);
  // Registered one-cycle pulses, blind to any enable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) evt <= 5'h00;
    else evt <= fire;
  end
endmodule : pif_src

// File: bench/tb_peripheral_interrupt_flags.sv
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb_peripheral_interrupt_flags;
  logic clk = 0, reset = 1, pig = 0, ga = 1, rx = 0, tx = 0, pwm = 0, cc2 = 0;
  logic [4:0] fire = 5'h00, evt;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0, rdata, d, m;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  logic [7:0] en;
  int bad_count = 0, cmp_count = 0, s;
  always #2.5 clk = ~clk;
  pif_top DUT (.clk(clk), .reset(reset), .ce(1'h1), .peripheral_int_gate(pig),
    .gate_active(ga), .conversion_done_evt(evt[4]), .serial_rx_full(rx), .serial_tx_empty(tx),
    .sync_port_done_evt(evt[3]), .capcmp_one_evt(evt[2]), .capcmp_one_pwm(pwm),
    .period_match_evt(evt[1]), .timer_one_ovf_evt(evt[0]), .capcmp_two_flag(cc2),
    .peripheral_int_req(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  pif_src SRC (.clk(clk), .reset(reset), .fire(fire), .evt(evt));
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task wr(input logic [3:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0; r = bresp;
    if (n == 40) begin bad_count++; final_report; end
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] v);
    int n;
    @(posedge clk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rready <= 1'h0; v = rdata; r = rresp;
    if (n == 40) begin bad_count++; final_report; end
  endtask : rd
  // Flags expected from fired events and source levels
  function logic [7:0] exp_req(input logic [4:0] f, input logic g, x, t, p);
    return {~g, f[4], x, t, f[3], f[2] & ~p, f[1], f[0]};
  endfunction : exp_req
  initial begin
    s = $urandom(83511);
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    rd(4'h0, d); `CHK(d, 32'h0)
    rd(4'h4, d); `CHK(d, 32'h0)
    rd(4'h8, d); `CHK(d, 32'h0)
    $display("reset values done");
    wr(4'h4, 32'hFF); rd(4'h4, d); `CHK(d, 32'h1)
    wr(4'hC, 32'hFF); `CHK(r, 2'h2)
    rd(4'hC, d); `CHK({r, d}, {2'h2, 32'h0})
    $display("map done");
    for (int i = 0; i < 8; i++) begin
      wr(4'h8, 32'h0);
      en = 8'($urandom);
      wr(4'h0, {24'h0, en}); rd(4'h0, d); `CHK(d, {24'h0, en})
      m = $urandom;
      fire <= m[4:0];
      {pig, ga, rx, tx, pwm, cc2} <= m[10:5];
      @(posedge clk);
      fire <= 5'h00;
      repeat (4) @(posedge clk);
      `CHK(irq, pig & (|(exp_req(m[4:0], ga, rx, tx, pwm) & en) | cc2))
      rd(4'h8, d); `CHK(d, {24'h0, exp_req(m[4:0], ga, rx, tx, pwm)})
      wr(4'h8, 32'h0); rd(4'h8, d); `CHK(d[7:0], exp_req(5'h0, ga, rx, tx, pwm))
      $display("random round %0d done", i);
    end
    // Overflow pulse lands on the edge that commits the clearing write
    fork
      wr(4'h8, 32'h0);
      begin
        @(posedge clk);
        fire <= 5'h01;
        @(posedge clk);
        fire <= 5'h00;
      end
    join
    rd(4'h8, d); `CHK(d[7:0], exp_req(5'h01, ga, rx, tx, pwm))
    wr(4'h8, 32'h0);
    $display("collision done");
    // Second enable masks the held flag
    wr(4'h0, 32'h0); wr(4'h4, 32'h0);
    cc2 <= 1'h1; pig <= 1'h1;
    repeat (4) @(posedge clk);
    `CHK(irq, 1'h0)
    $display("mask done");
    final_report;
  end
endmodule : tb_peripheral_interrupt_flags
